// >>> design/ttc_timer_unit.sv
// Two gated 16-bit timer/counters and a 16-bit timer, all with prescalers, external interrupt
// capture and an APB register slave.
// Assumes pins are asynchronous to pclk; the interrupt controller sits outside.
//
// The APB register port was decided locally.
`timescale 1ns/10ps
module ttc_timer_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_irq_a_pin,
    input wire logic ext_irq_b_pin,
    input wire logic first_timer_count_pin,
    input wire logic second_timer_count_pin,
    output logic first_timer_irq,
    output logic second_timer_irq,
    output logic third_timer_irq,
    output logic ext_irq_a_irq,
    output logic ext_irq_b_irq
);
    logic [7:0] control;
    logic [7:0] mode;
    logic [7:0] t2_control;
    logic [7:0] prescale;
    logic [7:0] t0_low, t0_high, t1_low, t1_high, t2_low, t2_high;

    // Two-flop synchronisers for the four pins
    logic [3:0] pin_meta, pin_sync, pin_prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= 4'hf;
            pin_sync <= 4'hf;
            pin_prev <= 4'hf;
        end else begin
            pin_meta <= {second_timer_count_pin, first_timer_count_pin,
                         ext_irq_b_pin, ext_irq_a_pin};
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end
    logic [3:0] pin_fall;
    assign pin_fall = pin_prev & ~pin_sync;

    // Free-running prescale counters shared by the three timers
    logic [6:0] cnt12, cnt96;
    logic tick12, tick96;
    assign tick12 = (cnt12 == ttc_pkg::DIV12_LAST);
    assign tick96 = (cnt96 == ttc_pkg::DIV96_LAST);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt12 <= 7'h00;
            cnt96 <= 7'h00;
        end else begin
            cnt12 <= tick12 ? 7'h00 : cnt12 + 7'h01;
            cnt96 <= tick96 ? 7'h00 : cnt96 + 7'h01;
        end
    end

    function automatic logic ps_tick(input logic [1:0] code, input logic t12,
                                     input logic t96);
        case (ttc_pkg::ttc_prescale_t'(code))
            ttc_pkg::TTC_PS_DIV12: ps_tick = t12;
            ttc_pkg::TTC_PS_DIV1: ps_tick = 1'b1;
            ttc_pkg::TTC_PS_DIV96: ps_tick = t96;
            default: ps_tick = 1'b0;
        endcase
    endfunction

    // Gated units count falls of the interrupt pin while it reads high;
    // a fall cycle sees the pin's previous high level.
    function automatic logic unit_step(input logic run, input logic gate,
                                       input logic cnt_sel, input logic ps,
                                       input logic cnt_fall, input logic irq_fall);
        if (!run)
            unit_step = 1'b0;
        else if (gate)
            unit_step = irq_fall;
        else if (cnt_sel)
            unit_step = cnt_fall;
        else
            unit_step = ps;
    endfunction

    // Next count for one 16-bit pair; returns {overflow, high, low}
    function automatic logic [16:0] count_pair(input logic [1:0] md,
                                               input logic [7:0] lo,
                                               input logic [7:0] hi);
        logic [16:0] r;
        logic [8:0] l9;
        r = {1'b0, hi, lo};
        l9 = {1'b0, lo} + 9'h001;
        case (ttc_pkg::ttc_mode_t'(md))
            ttc_pkg::TTC_MODE_13BIT: begin
                if (lo[4:0] == 5'h1f)
                    r = {(hi == 8'hff), hi + 8'h01, 8'h00};
                else
                    r = {1'b0, hi, 3'b000, lo[4:0] + 5'h01};
            end
            ttc_pkg::TTC_MODE_16BIT: begin
                r = {1'b0, hi, lo} + 17'h00001;
            end
            ttc_pkg::TTC_MODE_RELOAD: begin
                r = l9[8] ? {1'b1, hi, hi} : {1'b0, hi, l9[7:0]};
            end
            default: begin // Split low byte
                r = {l9[8], hi, l9[7:0]};
            end
        endcase
        return r;
    endfunction

    logic [1:0] t0_mode, t1_mode, t2_mode;
    assign t0_mode = mode[ttc_pkg::MOD_M0_HI:ttc_pkg::MOD_M0_LO];
    assign t1_mode = mode[ttc_pkg::MOD_M1_HI:ttc_pkg::MOD_M1_LO];
    assign t2_mode = t2_control[ttc_pkg::T2_MODE_HI:ttc_pkg::T2_MODE_LO];

    logic t0_ps, t1_ps, t2_ps, t0_step, t1_step, t0h_step, t2_step;
    assign t0_ps = ps_tick(prescale[ttc_pkg::PS_T0_LO+:2], tick12, tick96);
    assign t1_ps = ps_tick(prescale[ttc_pkg::PS_T1_LO+:2], tick12, tick96);
    assign t2_ps = ps_tick(t2_control[ttc_pkg::T2_PS_HI:ttc_pkg::T2_PS_LO],
                           tick12, tick96);
    assign t0_step = unit_step(control[ttc_pkg::CTL_TR0], mode[ttc_pkg::MOD_FIRST_TIMER_PIN_GATE],
                               mode[ttc_pkg::MOD_CT0], t0_ps, pin_fall[2], pin_fall[0]);
    assign t1_step = (t1_mode != 2'b11) && unit_step(control[ttc_pkg::CTL_TR1],
                     mode[ttc_pkg::MOD_SECOND_TIMER_PIN_GATE], mode[ttc_pkg::MOD_CT1], t1_ps,
                     pin_fall[3], pin_fall[1]);
    // Split high byte is a plain timer on timer0's prescale, run by timer1's bit
    assign t0h_step = control[ttc_pkg::CTL_TR1] && t0_ps;
    assign t2_step = t2_control[ttc_pkg::T2_TR] && t2_ps;

    logic [16:0] t0_next, t1_next, t2_next;
    logic [8:0] t0h_next;
    assign t0_next = count_pair(t0_mode, t0_low, t0_high);
    assign t1_next = count_pair(t1_mode, t1_low, t1_high);
    assign t2_next = count_pair(t2_mode, t2_low, t2_high);
    assign t0h_next = {1'b0, t0_high} + 9'h001;

    logic t0_ovf, t1_ovf, t2_ovf;
    assign t0_ovf = t0_step && t0_next[16];
    assign t1_ovf = (t1_step && t1_next[16]) ||
                    (t0_mode == 2'b11 && t0h_step && t0h_next[8]);
    assign t2_ovf = t2_step && t2_next[16];

    // APB decode: index is byte address divided by four
    logic wr_en, rd_en, hit;
    logic [7:0] idx, wbyte;
    assign idx = paddr[9:2];
    assign wbyte = pwdata[7:0];
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    always_comb begin
        case (idx)
            ttc_pkg::IDX_T01_CONTROL, ttc_pkg::IDX_T01_MODE, ttc_pkg::IDX_T0_LOW,
            ttc_pkg::IDX_T1_LOW, ttc_pkg::IDX_T0_HIGH, ttc_pkg::IDX_T1_HIGH,
            ttc_pkg::IDX_T2_LOW, ttc_pkg::IDX_T2_HIGH, ttc_pkg::IDX_T2_CONTROL,
            ttc_pkg::IDX_PRESCALE, ttc_pkg::IDX_IRQ_ACK: hit = (paddr[11:10] == 2'b00);
            default: hit = 1'b0;
        endcase
    end
    logic [4:0] ack;
    assign ack = (wr_en && idx == ttc_pkg::IDX_IRQ_ACK) ? wbyte[4:0] : 5'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= ttc_pkg::RESET_BYTE;
            prescale <= ttc_pkg::RESET_BYTE;
        end else if (wr_en) begin
            if (idx == ttc_pkg::IDX_T01_MODE)
                mode <= wbyte;
            if (idx == ttc_pkg::IDX_PRESCALE)
                prescale <= wbyte & ttc_pkg::PS_MASK;
        end
    end

    // External interrupt capture; low-level mode re-asserts while held low
    logic ie0_set, ie1_set;
    assign ie0_set = control[ttc_pkg::CTL_IT0] ? pin_fall[0] : !pin_sync[0];
    assign ie1_set = control[ttc_pkg::CTL_IT1] ? pin_fall[1] : !pin_sync[1];

    function automatic logic flag_next(input logic cur, input logic set,
                                       input logic wr, input logic wval,
                                       input logic clr);
        logic v;
        v = wr ? wval : cur;
        if (clr)
            v = 1'b0;
        flag_next = v | set;
    endfunction

    logic cw;
    assign cw = wr_en && idx == ttc_pkg::IDX_T01_CONTROL;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control <= ttc_pkg::RESET_BYTE;
        end else begin
            if (cw) begin
                control[ttc_pkg::CTL_TR1] <= wbyte[ttc_pkg::CTL_TR1];
                control[ttc_pkg::CTL_TR0] <= wbyte[ttc_pkg::CTL_TR0];
                control[ttc_pkg::CTL_IT1] <= wbyte[ttc_pkg::CTL_IT1];
                control[ttc_pkg::CTL_IT0] <= wbyte[ttc_pkg::CTL_IT0];
            end
            control[ttc_pkg::CTL_TF1] <= flag_next(control[ttc_pkg::CTL_TF1], t1_ovf, cw,
                wbyte[ttc_pkg::CTL_TF1], ack[ttc_pkg::ACK_TF1]);
            control[ttc_pkg::CTL_TF0] <= flag_next(control[ttc_pkg::CTL_TF0], t0_ovf, cw,
                wbyte[ttc_pkg::CTL_TF0], ack[ttc_pkg::ACK_TF0]);
            control[ttc_pkg::CTL_IE1] <= flag_next(control[ttc_pkg::CTL_IE1], ie1_set, cw,
                wbyte[ttc_pkg::CTL_IE1], ack[ttc_pkg::ACK_IE1]);
            control[ttc_pkg::CTL_IE0] <= flag_next(control[ttc_pkg::CTL_IE0], ie0_set, cw,
                wbyte[ttc_pkg::CTL_IE0], ack[ttc_pkg::ACK_IE0]);
        end
    end

    logic t2w;
    assign t2w = wr_en && idx == ttc_pkg::IDX_T2_CONTROL;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t2_control <= ttc_pkg::RESET_BYTE;
        end else begin
            if (t2w)
                t2_control[ttc_pkg::T2_TR:0] <= wbyte[ttc_pkg::T2_TR:0];
            t2_control[ttc_pkg::T2_TF] <= flag_next(t2_control[ttc_pkg::T2_TF], t2_ovf,
                t2w, wbyte[ttc_pkg::T2_TF], ack[ttc_pkg::ACK_TF2]);
        end
    end

    // Counters: a software write to a byte wins over a count in that cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t0_low <= ttc_pkg::RESET_BYTE;
            t0_high <= ttc_pkg::RESET_BYTE;
        end else begin
            if (t0_step)
                {t0_high, t0_low} <= t0_next[15:0];
            else if (t0_mode == 2'b00)
                t0_low <= t0_low & ttc_pkg::MODE0_LOW_MASK;
            if (t0_mode == 2'b11 && t0h_step)
                t0_high <= t0h_next[7:0];
            if (wr_en && idx == ttc_pkg::IDX_T0_LOW)
                t0_low <= wbyte;
            if (wr_en && idx == ttc_pkg::IDX_T0_HIGH)
                t0_high <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_low <= ttc_pkg::RESET_BYTE;
            t1_high <= ttc_pkg::RESET_BYTE;
        end else begin
            if (t1_step)
                {t1_high, t1_low} <= t1_next[15:0];
            else if (t1_mode == 2'b00)
                t1_low <= t1_low & ttc_pkg::MODE0_LOW_MASK;
            if (wr_en && idx == ttc_pkg::IDX_T1_LOW)
                t1_low <= wbyte;
            if (wr_en && idx == ttc_pkg::IDX_T1_HIGH)
                t1_high <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t2_low <= ttc_pkg::RESET_BYTE;
            t2_high <= ttc_pkg::RESET_BYTE;
        end else begin
            if (t2_step)
                {t2_high, t2_low} <= t2_next[15:0];
            else if (t2_mode == 2'b00)
                t2_low <= t2_low & ttc_pkg::MODE0_LOW_MASK;
            if (wr_en && idx == ttc_pkg::IDX_T2_LOW)
                t2_low <= wbyte;
            if (wr_en && idx == ttc_pkg::IDX_T2_HIGH)
                t2_high <= wbyte;
        end
    end

    // Read data is captured in the setup cycle so the access phase has it
    logic [7:0] rbyte;
    always_comb begin
        case (idx)
            ttc_pkg::IDX_T01_CONTROL: rbyte = control;
            ttc_pkg::IDX_T01_MODE: rbyte = mode;
            ttc_pkg::IDX_T0_LOW: rbyte = t0_low;
            ttc_pkg::IDX_T1_LOW: rbyte = t1_low;
            ttc_pkg::IDX_T0_HIGH: rbyte = t0_high;
            ttc_pkg::IDX_T1_HIGH: rbyte = t1_high;
            ttc_pkg::IDX_T2_LOW: rbyte = t2_low;
            ttc_pkg::IDX_T2_HIGH: rbyte = t2_high;
            ttc_pkg::IDX_T2_CONTROL: rbyte = t2_control & ttc_pkg::T2_CTL_MASK;
            ttc_pkg::IDX_PRESCALE: rbyte = prescale;
            default: rbyte = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            if (rd_en)
                prdata <= hit ? {24'h000000, rbyte} : 32'h0000_0000;
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_timer_irq <= 1'b0;
            second_timer_irq <= 1'b0;
            third_timer_irq <= 1'b0;
            ext_irq_a_irq <= 1'b0;
            ext_irq_b_irq <= 1'b0;
        end else begin
            first_timer_irq <= control[ttc_pkg::CTL_TF0];
            second_timer_irq <= control[ttc_pkg::CTL_TF1];
            third_timer_irq <= t2_control[ttc_pkg::T2_TF];
            ext_irq_a_irq <= control[ttc_pkg::CTL_IE0];
            ext_irq_b_irq <= control[ttc_pkg::CTL_IE1];
        end
    end
endmodule

// >>> design/ttc_pkg.sv
// Package for the triple timer/counter unit: register map, field positions,
// reset values, prescale codes and mode codes.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package ttc_pkg;
    // Printed offsets are not all multiples of four: they are indices
    localparam logic [7:0] IDX_T01_CONTROL = 8'h88;
    localparam logic [7:0] IDX_T01_MODE = 8'h89;
    localparam logic [7:0] IDX_T0_LOW = 8'h8a;
    localparam logic [7:0] IDX_T1_LOW = 8'h8b;
    localparam logic [7:0] IDX_T0_HIGH = 8'h8c;
    localparam logic [7:0] IDX_T1_HIGH = 8'h8d;
    localparam logic [7:0] IDX_T2_LOW = 8'hb4;
    localparam logic [7:0] IDX_T2_HIGH = 8'hb5;
    localparam logic [7:0] IDX_T2_CONTROL = 8'hc8;
    localparam logic [7:0] IDX_PRESCALE = 8'hd1;
    localparam logic [7:0] IDX_IRQ_ACK = 8'he0;

    // Control register fields
    localparam int CTL_TF1 = 7;
    localparam int CTL_TR1 = 6;
    localparam int CTL_TF0 = 5;
    localparam int CTL_TR0 = 4;
    localparam int CTL_IE1 = 3;
    localparam int CTL_IT1 = 2;
    localparam int CTL_IE0 = 1;
    localparam int CTL_IT0 = 0;
    // Mode register fields
    localparam int MOD_SECOND_TIMER_PIN_GATE = 7;
    localparam int MOD_CT1 = 6;
    localparam int MOD_M1_HI = 5;
    localparam int MOD_M1_LO = 4;
    localparam int MOD_FIRST_TIMER_PIN_GATE = 3;
    localparam int MOD_CT0 = 2;
    localparam int MOD_M0_HI = 1;
    localparam int MOD_M0_LO = 0;
    // Timer2 control fields
    localparam int T2_TF = 5;
    localparam int T2_TR = 4;
    localparam int T2_MODE_HI = 3;
    localparam int T2_MODE_LO = 2;
    localparam int T2_PS_HI = 1;
    localparam int T2_PS_LO = 0;
    localparam logic [7:0] T2_CTL_MASK = 8'h3f;
    // Prescale register fields
    localparam int PS_T1_LO = 2;
    localparam int PS_T0_LO = 0;
    localparam logic [7:0] PS_MASK = 8'h3f;
    // Acknowledge register: one bit per serviced vector
    localparam int ACK_IE0 = 0;
    localparam int ACK_TF0 = 1;
    localparam int ACK_IE1 = 2;
    localparam int ACK_TF1 = 3;
    localparam int ACK_TF2 = 4;

    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] MODE0_LOW_MASK = 8'h1f;

    localparam logic [6:0] DIV12_LAST = 7'h0b;
    localparam logic [6:0] DIV96_LAST = 7'h5f;

    typedef enum logic [1:0] {
        TTC_PS_DIV12 = 2'b00,
        TTC_PS_DIV1 = 2'b01,
        TTC_PS_DIV96 = 2'b10,
        TTC_PS_NONE = 2'b11
    } ttc_prescale_t;

    typedef enum logic [1:0] {
        TTC_MODE_13BIT = 2'b00,
        TTC_MODE_16BIT = 2'b01,
        TTC_MODE_RELOAD = 2'b10,
        TTC_MODE_SPLIT = 2'b11
    } ttc_mode_t;
endpackage

// >>> testbench/ttc_core_model.sv
// Bus master that stands in for the processor core on the register bus.
// Assumes each transfer is started just after a rising edge of pclk.
`timescale 1ns/10ps
module ttc_core_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                        output logic [7:0] q, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle data is scrambled so a stale word is never taken as live
        pwdata <= ~pwdata;
        // One idle cycle keeps the strobes from being driven twice in one step
        @(posedge pclk);
    endtask
endmodule

// >>> testbench/ttc_timer_unit_props.sv
// Checker of the bus answer and the request outputs, bound to the unit.
// Assumes one pclk domain with presetn as its reset.
`timescale 1ns/10ps
module ttc_timer_unit_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic first_timer_irq,
    input wire logic second_timer_irq,
    input wire logic third_timer_irq,
    input wire logic ext_irq_a_irq,
    input wire logic ext_irq_b_irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic acc;
    logic wacc;
    logic hit;
    logic [7:0] idx;
    assign idx = paddr[9:2];
    assign acc = psel && penable;
    assign wacc = acc && pwrite;
    assign hit = (paddr[11:10] == 2'b00) && (idx inside {ttc_pkg::IDX_T01_CONTROL,
        ttc_pkg::IDX_T01_MODE, ttc_pkg::IDX_T0_LOW, ttc_pkg::IDX_T1_LOW, ttc_pkg::IDX_T0_HIGH,
        ttc_pkg::IDX_T1_HIGH, ttc_pkg::IDX_T2_LOW, ttc_pkg::IDX_T2_HIGH,
        ttc_pkg::IDX_T2_CONTROL, ttc_pkg::IDX_PRESCALE, ttc_pkg::IDX_IRQ_ACK});
    // A flag only falls after some register write has landed
    property held(x);
        x && !$past(wacc) |=> x;
    endproperty
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    access_ready_a: assert property (acc |-> pready)
        else $error("access cycle without pready");
    ready_cause_a: assert property (pready |-> acc)
        else $error("pready outside an access cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (acc && !hit |-> pslverr)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc && hit |-> !pslverr)
        else $error("mapped access refused");
    upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    rdata_hold_a: assert property (pready |=> $stable(prdata))
        else $error("read data changed after the answer");
    ack_zero_a: assert property (acc && !pwrite && idx == ttc_pkg::IDX_IRQ_ACK
        |-> prdata == 32'h0) else $error("acknowledge register read not zero");
    ctl_irq_a: assert property (pready && !pwrite && idx == ttc_pkg::IDX_T01_CONTROL
        |-> {prdata[7], prdata[5], prdata[3], prdata[1]} == {second_timer_irq,
        first_timer_irq, ext_irq_b_irq, ext_irq_a_irq}) else $error("request differs from flag");
    t2_irq_a: assert property (pready && !pwrite && idx == ttc_pkg::IDX_T2_CONTROL
        |-> prdata[5] == third_timer_irq) else $error("timer2 request differs from flag");
    hold_t0_a: assert property (held(first_timer_irq))
        else $error("timer0 request dropped without a write");
    hold_t2_a: assert property (held(third_timer_irq))
        else $error("timer2 request dropped without a write");
    hold_extb_a: assert property (held(ext_irq_b_irq))
        else $error("pin b request dropped without a write");
    cover property (pslverr);
    cover property ($rose(first_timer_irq));
    cover property ($rose(ext_irq_b_irq));
endmodule
bind ttc_timer_unit ttc_timer_unit_props i_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .first_timer_irq(first_timer_irq), .second_timer_irq(second_timer_irq),
    .third_timer_irq(third_timer_irq), .ext_irq_a_irq(ext_irq_a_irq),
    .ext_irq_b_irq(ext_irq_b_irq));

// >>> testbench/ttc_timer_unit_bench.sv
// Self-checking bench of the triple timer/counter unit.
// Assumes the core model as bus master; pins are driven from here.
`timescale 1ns/10ps
module ttc_timer_unit_bench;
    localparam logic [7:0] CT = ttc_pkg::IDX_T01_CONTROL;
    localparam logic [7:0] MD = ttc_pkg::IDX_T01_MODE;
    localparam logic [7:0] PS = ttc_pkg::IDX_PRESCALE;
    localparam logic [7:0] C2 = ttc_pkg::IDX_T2_CONTROL;
    localparam logic [7:0] AK = ttc_pkg::IDX_IRQ_ACK;
    logic [7:0] lo_idx [3] = '{ttc_pkg::IDX_T0_LOW, ttc_pkg::IDX_T1_LOW, ttc_pkg::IDX_T2_LOW};
    logic [7:0] hi_idx [3] = '{ttc_pkg::IDX_T0_HIGH, ttc_pkg::IDX_T1_HIGH, ttc_pkg::IDX_T2_HIGH};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pin_a, pin_b, cnt0, cnt1, irq0, irq1, irq2, irqa, irqb;
    logic [7:0] q, x, v, k0, cd;
    int n_fail, n_compared, cycles, seed, n, dv;

    ttc_timer_unit i_ttc_timer_unit (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_irq_a_pin(pin_a), .ext_irq_b_pin(pin_b),
        .first_timer_count_pin(cnt0), .second_timer_count_pin(cnt1), .first_timer_irq(irq0),
        .second_timer_irq(irq1), .third_timer_irq(irq2), .ext_irq_a_irq(irqa),
        .ext_irq_b_irq(irqb));
    ttc_core_model core (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    task automatic chk(input logic [7:0] s, input logic [7:0] xp);
        n_compared++;
        if (s !== xp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, s, xp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic er;
        core.xfer(1'b1, a, d, r, er);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] r, output logic er);
        core.xfer(1'b0, a, 8'h00, r, er);
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] xp);
        logic [7:0] r;
        logic er;
        rd(a, r, er);
        chk(r, xp);
    endtask
    task automatic complete_run();
        $display("fails %0d compares %0d", n_fail, n_compared);
        if (n_fail == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        seed = 32'h2b64ed7d;
        presetn = 1'b0;
        {pin_a, pin_b, cnt0, cnt1} = 4'hf;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rc(CT, 8'h00);
        rc(MD, 8'h00);
        rc(C2, 8'h00);
        rc(PS, 8'h00);
        rd(8'h10, q, e);
        chk({7'h0, e}, 8'h01);
        chk(q, 8'h00);
        for (int i = 0; i < 4; i++) begin
            v = 8'($random(seed));
            wr(PS, v);
            rc(PS, v & ttc_pkg::PS_MASK);
            wr(C2, v & 8'hcf);
            rc(C2, v & 8'h0f);
            wr(MD, v);
            rc(MD, v);
        end
        // Thirteen-bit count wraps where a sixteen-bit one would not
        wr(MD, 8'h00);
        wr(lo_idx[0], 8'hff);
        rc(lo_idx[0], 8'h1f);
        wr(hi_idx[0], 8'hff);
        wr(lo_idx[0], 8'h1e);
        wr(PS, 8'h01);
        wr(CT, 8'h10);
        repeat (8) @(posedge pclk);
        rc(CT, 8'h30);
        wr(CT, 8'h00);
        rc(CT, 8'h00);
        for (int t = 0; t < 3; t++) begin
            for (int c = 0; c < 3; c++) begin
                n = 20 + ($unsigned($random(seed)) % 200);
                dv = (c == 0) ? 12 : (c == 1) ? 1 : 96;
                cd = 8'(c);
                wr(MD, 8'h11);
                wr(PS, {4'h0, cd[1:0], cd[1:0]});
                wr(lo_idx[t], 8'h00);
                wr(hi_idx[t], 8'h00);
                if (t < 2)
                    wr(CT, (t == 0) ? 8'h10 : 8'h40);
                else
                    wr(C2, 8'h14 | cd);
                repeat (n) @(posedge pclk);
                if (t < 2)
                    wr(CT, 8'h00);
                else
                    wr(C2, 8'h04 | cd);
                rd(lo_idx[t], q, e);
                // Ticks land on every dv-th edge from the one after the run write to the stop write
                x = 8'((n + 3) / dv);
                chk((q >= x && q <= x + 8'h01) ? x : q, x);
            end
        end
        wr(MD, 8'h20);
        wr(PS, 8'h04);
        wr(hi_idx[1], 8'hf0);
        wr(lo_idx[1], 8'hfe);
        wr(CT, 8'h40);
        repeat (30) @(posedge pclk);
        rc(CT, 8'hc0);
        wr(CT, 8'h80);
        rd(lo_idx[1], q, e);
        chk((q >= 8'hf0) ? 8'hf0 : q, 8'hf0);
        chk({7'h0, irq1}, 8'h01);
        wr(AK, 8'h08);
        rc(CT, 8'h00);
        wr(hi_idx[2], 8'hf0);
        wr(lo_idx[2], 8'hfe);
        wr(C2, 8'h19);
        repeat (30) @(posedge pclk);
        rc(C2, 8'h39);
        chk({7'h0, irq2}, 8'h01);
        wr(C2, 8'h29);
        rd(lo_idx[2], q, e);
        chk((q >= 8'hf0) ? 8'hf0 : q, 8'hf0);
        wr(AK, 8'h10);
        rc(C2, 8'h09);
        wr(PS, 8'h05);
        wr(MD, 8'h33);
        wr(lo_idx[0], 8'hfd);
        wr(hi_idx[0], 8'hfe);
        wr(lo_idx[1], 8'h05);
        wr(CT, 8'h10);
        repeat (20) @(posedge pclk);
        rc(CT, 8'h30);
        rc(hi_idx[0], 8'hfe);
        wr(CT, 8'h50);
        repeat (20) @(posedge pclk);
        // Timer0 flag was cleared by the run write and the low byte has not wrapped again
        rc(CT, 8'hd0);
        rc(lo_idx[1], 8'h05);
        wr(MD, 8'h00);
        wr(CT, 8'h01);
        pin_a <= 1'b0;
        repeat (6) @(posedge pclk);
        rc(CT, 8'h03);
        chk({7'h0, irqa}, 8'h01);
        wr(AK, 8'h01);
        rc(CT, 8'h01);
        pin_a <= 1'b1;
        pin_b <= 1'b0;
        repeat (6) @(posedge pclk);
        rc(CT, 8'h09);
        wr(AK, 8'h04);
        rc(CT, 8'h09);
        pin_b <= 1'b1;
        repeat (4) @(posedge pclk);
        wr(AK, 8'h04);
        rc(CT, 8'h01);
        for (int g = 0; g < 2; g++) begin
            k0 = 8'(1 + ($unsigned($random(seed)) % 6));
            wr(MD, (g == 1) ? 8'h99 : 8'h55);
            wr(lo_idx[0], 8'h00);
            wr(lo_idx[1], 8'h00);
            wr(CT, 8'h50);
            for (int i = 0; i <= k0; i++) begin
                if (g == 1) begin
                    pin_a <= !(i < k0);
                    pin_b <= 1'b0;
                end else begin
                    cnt0 <= !(i < k0);
                    cnt1 <= 1'b0;
                end
                repeat (4) @(posedge pclk);
                {pin_a, pin_b, cnt0, cnt1} <= 4'hf;
                repeat (4) @(posedge pclk);
            end
            repeat (4) @(posedge pclk);
            rc(lo_idx[0], k0);
            rc(lo_idx[1], k0 + 8'h01);
            wr(CT, 8'h00);
        end
        complete_run();
    end
endmodule
